//--- verilog/aseco_dev.sv
// Serial device end: base clock, enable sync, transmitter and receiver
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module aseco_dev #(
	parameter int BIT_TICKS = aseco_pkg::BIT_TICKS
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	aseco_if.dev      lnk,
	input  wire logic serial_rx_pin,
	output logic      serial_tx_pin
);
	localparam int CW = $clog2(BIT_TICKS);
	localparam logic [CW-1:0] LAST = CW'(BIT_TICKS - 1);
	localparam logic [CW-1:0] HALF = CW'(BIT_TICKS / 2 - 1);

	if (BIT_TICKS < 4 || BIT_TICKS > 256) begin : g_chk
		$error("aseco_dev: BIT_TICKS must lie in 4 to 256");
	end

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} aseco_tx_st_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} aseco_rx_st_t;

	// Parity bit to send, or to expect, for the chosen length
	function automatic logic par_bit(input logic [7:0] d, input logic cl, input logic [1:0] ps);
		logic x;
		x = cl ? ^d : ^d[6:0];
		par_bit = (ps == aseco_pkg::PAR_ODD) ? ~x : ((ps == aseco_pkg::PAR_EVEN) ? x : 1'b0);
	endfunction

	// Base clock, pin sync and enable sync
	logic [aseco_pkg::DIV_W-1:0] pre_q;
	logic [aseco_pkg::DIV_W-1:0] pre_d;
	logic                        tick;
	logic                        rx_meta_q;
	logic                        rx_sync_q;
	logic                        txe_q;
	logic                        txe_d;
	logic                        rxe_q;
	logic                        rxe_d;

	always_comb begin
		tick = lnk.power_en && (pre_q == lnk.clk_div);
		pre_d = (!lnk.power_en || tick) ? '0 : pre_q + 1'b1;
		txe_d = txe_q;
		rxe_d = rxe_q;
		if (!lnk.power_en) begin
			txe_d = 1'b0;
			rxe_d = 1'b0;
		end else if (tick) begin
			txe_d = lnk.tx_enable;
			rxe_d = lnk.rx_enable;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pre_q <= '0;
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
			txe_q <= 1'b0;
			rxe_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			rx_meta_q <= serial_rx_pin;
			rx_sync_q <= rx_meta_q;
			txe_q <= txe_d;
			rxe_q <= rxe_d;
		end
	end

	// Transmitter
	aseco_tx_st_t   tst_q;
	aseco_tx_st_t   tst_d;
	logic [CW-1:0]  tcnt_q;
	logic [CW-1:0]  tcnt_d;
	logic [2:0]     tidx_q;
	logic [2:0]     tidx_d;
	logic [7:0]     tsh_q;
	logic [7:0]     tsh_d;
	logic           tpar_q;
	logic           tpar_d;
	logic           tstop_q;
	logic           tstop_d;
	logic           txo_q;
	logic           txo_d;
	logic           tdone_q;
	logic           tdone_d;
	logic           tend;

	always_comb begin
		tst_d = tst_q;
		tcnt_d = tcnt_q;
		tidx_d = tidx_q;
		tsh_d = tsh_q;
		tpar_d = tpar_q;
		tstop_d = tstop_q;
		txo_d = txo_q;
		tdone_d = 1'b0;
		tend = tick && (tcnt_q == LAST);
		if (tick) begin
			tcnt_d = tend ? '0 : tcnt_q + 1'b1;
		end
		unique case (tst_q)
			TX_IDLE: begin
				txo_d = 1'b1;
				tcnt_d = '0;
				if (txe_q && lnk.tx_write) begin
					tst_d = TX_START;
					tsh_d = lnk.tx_data;
					tpar_d = par_bit(lnk.tx_data, lnk.char_len_sel, lnk.parity_sel);
					tstop_d = lnk.stop_len_sel;
					tidx_d = '0;
					txo_d = 1'b0;
				end
			end
			TX_START: if (tend) begin
				tst_d = TX_DATA;
				txo_d = tsh_q[0];
			end
			TX_DATA: if (tend) begin
				tsh_d = tsh_q >> 1;
				tidx_d = tidx_q + 1'b1;
				if (tidx_q == (lnk.char_len_sel ? 3'h7 : 3'h6)) begin
					if (lnk.parity_sel == aseco_pkg::PAR_NONE) begin
						tst_d = TX_STOP;
						txo_d = 1'b1;
					end else begin
						tst_d = TX_PAR;
						txo_d = tpar_q;
					end
				end else begin
					txo_d = tsh_q[1];
				end
			end
			TX_PAR: if (tend) begin
				tst_d = TX_STOP;
				txo_d = 1'b1;
			end
			TX_STOP: if (tend) begin
				if (tstop_q) begin
					tstop_d = 1'b0;
				end else begin
					tst_d = TX_IDLE;
					tdone_d = 1'b1;
				end
			end
		endcase
		// Disabled transmitter is held initialised
		if (!txe_q) begin
			tst_d = TX_IDLE;
			txo_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tst_q <= TX_IDLE;
			tcnt_q <= '0;
			tidx_q <= '0;
			tsh_q <= '0;
			tpar_q <= 1'b0;
			tstop_q <= 1'b0;
			txo_q <= 1'b1;
			tdone_q <= 1'b0;
		end else begin
			tst_q <= tst_d;
			tcnt_q <= tcnt_d;
			tidx_q <= tidx_d;
			tsh_q <= tsh_d;
			tpar_q <= tpar_d;
			tstop_q <= tstop_d;
			txo_q <= txo_d;
			tdone_q <= tdone_d;
		end
	end

	// Receiver
	aseco_rx_st_t                rst_q;
	aseco_rx_st_t                rst_d;
	logic [CW-1:0]               rcnt_q;
	logic [CW-1:0]               rcnt_d;
	logic [2:0]                  ridx_q;
	logic [2:0]                  ridx_d;
	logic [7:0]                  rsh_q;
	logic [7:0]                  rsh_d;
	logic                        rperr_q;
	logic                        rperr_d;
	logic [7:0]                  rdata_q;
	logic [7:0]                  rdata_d;
	logic [aseco_pkg::ERR_W-1:0] rerr_q;
	logic [aseco_pkg::ERR_W-1:0] rerr_d;
	logic                        rdone_q;
	logic                        rdone_d;
	logic                        reirq_q;
	logic                        reirq_d;
	logic                        rend;
	logic [7:0]                  rword;

	always_comb begin
		rst_d = rst_q;
		rcnt_d = rcnt_q;
		ridx_d = ridx_q;
		rsh_d = rsh_q;
		rperr_d = rperr_q;
		rdata_d = rdata_q;
		rerr_d = rerr_q;
		rdone_d = 1'b0;
		reirq_d = 1'b0;
		rend = tick && (rcnt_q == LAST);
		rword = lnk.char_len_sel ? rsh_q : {1'b0, rsh_q[7:1]};
		if (tick) begin
			rcnt_d = rend ? '0 : rcnt_q + 1'b1;
		end
		unique case (rst_q)
			RX_IDLE: begin
				rcnt_d = '0;
				if (rxe_q && !rx_sync_q) begin
					rst_d = RX_START;
				end
			end
			RX_START: if (tick && rcnt_q == HALF) begin
				rcnt_d = '0;
				ridx_d = '0;
				rperr_d = 1'b0;
				rst_d = rx_sync_q ? RX_IDLE : RX_DATA;
			end
			RX_DATA: if (rend) begin
				rsh_d = {rx_sync_q, rsh_q[7:1]};
				ridx_d = ridx_q + 1'b1;
				if (ridx_q == (lnk.char_len_sel ? 3'h7 : 3'h6)) begin
					rst_d = (lnk.parity_sel == aseco_pkg::PAR_NONE) ? RX_STOP : RX_PAR;
				end
			end
			RX_PAR: if (rend) begin
				rst_d = RX_STOP;
				// Zero parity bit is consumed unchecked
				if (lnk.parity_sel == aseco_pkg::PAR_ODD || lnk.parity_sel == aseco_pkg::PAR_EVEN) begin
					rperr_d = rx_sync_q != par_bit(rword, lnk.char_len_sel, lnk.parity_sel);
				end
			end
			RX_STOP: if (rend) begin
				rst_d = RX_IDLE;
				rdata_d = rword;
				rerr_d[aseco_pkg::ERR_PARITY] = rperr_q;
				rerr_d[aseco_pkg::ERR_FRAME] = !rx_sync_q;
				if (rperr_q || !rx_sync_q) begin
					rdone_d = lnk.error_irq_route_sel;
					reirq_d = !lnk.error_irq_route_sel;
				end else begin
					rdone_d = 1'b1;
				end
			end
		endcase
		if (!rxe_q) begin
			rst_d = RX_IDLE;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_q <= RX_IDLE;
			rcnt_q <= '0;
			ridx_q <= '0;
			rsh_q <= '0;
			rperr_q <= 1'b0;
			rdata_q <= '0;
			rerr_q <= '0;
			rdone_q <= 1'b0;
			reirq_q <= 1'b0;
		end else begin
			rst_q <= rst_d;
			rcnt_q <= rcnt_d;
			ridx_q <= ridx_d;
			rsh_q <= rsh_d;
			rperr_q <= rperr_d;
			rdata_q <= rdata_d;
			rerr_q <= rerr_d;
			rdone_q <= rdone_d;
			reirq_q <= reirq_d;
		end
	end

	assign serial_tx_pin = txo_q;
	assign lnk.tx_busy = (tst_q != TX_IDLE);
	assign lnk.tx_done = tdone_q;
	assign lnk.rx_data = rdata_q;
	assign lnk.rx_error_status = rerr_q;
	assign lnk.rx_done_irq = rdone_q;
	assign lnk.rx_error_irq = reirq_q;
	assign lnk.base_tick = tick;
	assign lnk.rx_line_high = rx_sync_q;
endmodule

//--- verilog/aseco_pkg.sv
// Shared constants for the serial enable-control pair
package aseco_pkg;
	// Line timing
	localparam int BIT_TICKS      = 16;
	localparam int DIV_W          = 4;
	localparam int REENABLE_TICKS = 2;
	localparam int TXB_WAIT_TICKS = 1;
	// Parity select encodings
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD  = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;
	// Receive error status bits
	localparam int ERR_W      = 2;
	localparam int ERR_PARITY = 0;
	localparam int ERR_FRAME  = 1;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_MODE     = 8'h04;
	localparam logic [7:0] OFF_TXDATA   = 8'h08;
	localparam logic [7:0] OFF_RXDATA   = 8'h0C;
	localparam logic [7:0] OFF_STATUS   = 8'h10;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	// Control register bits
	localparam int CTRL_POWER = 0;
	localparam int CTRL_TX    = 1;
	localparam int CTRL_RX    = 2;
	// Mode register fields
	localparam int MODE_PAR   = 0;
	localparam int MODE_CHAR  = 2;
	localparam int MODE_STOP  = 3;
	localparam int MODE_ROUTE = 4;
	localparam int MODE_LIN   = 5;
	localparam int MODE_DIV   = 8;
	// Status register bits, and the offset of the error field in the receive data register
	localparam int ST_POWER = 0;
	localparam int ST_TX    = 1;
	localparam int ST_RX    = 2;
	localparam int ST_TXV   = 3;
	localparam int ST_BUSY  = 4;
	localparam int ST_PEND  = 5;
	localparam int ST_LINE  = 6;
	localparam int RXD_ERR  = 8;
	// Interrupt bits
	localparam int IRQ_W       = 3;
	localparam int IRQ_RX_DONE = 0;
	localparam int IRQ_RX_ERR  = 1;
	localparam int IRQ_TX_DONE = 2;
	// Reset values
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
endpackage

//--- verilog/aseco_if.sv
// Link between the serial device end and its controller end
`timescale 1ns/1ns
interface aseco_if;
	logic                            power_en;
	logic                            tx_enable;
	logic                            rx_enable;
	logic [1:0]                      parity_sel;
	logic                            char_len_sel;
	logic                            stop_len_sel;
	logic                            error_irq_route_sel;
	logic [aseco_pkg::DIV_W-1:0]     clk_div;
	logic [7:0]                      tx_data;
	logic                            tx_write;
	logic                            tx_busy;
	logic                            tx_done;
	logic [7:0]                      rx_data;
	logic [aseco_pkg::ERR_W-1:0]     rx_error_status;
	logic                            rx_done_irq;
	logic                            rx_error_irq;
	logic                            base_tick;
	logic                            rx_line_high;

	modport dev (
		input  power_en, tx_enable, rx_enable, parity_sel, char_len_sel, stop_len_sel,
		input  error_irq_route_sel, clk_div, tx_data, tx_write,
		output tx_busy, tx_done, rx_data, rx_error_status, rx_done_irq, rx_error_irq,
		output base_tick, rx_line_high
	);
	modport ctl (
		output power_en, tx_enable, rx_enable, parity_sel, char_len_sel, stop_len_sel,
		output error_irq_route_sel, clk_div, tx_data, tx_write,
		input  tx_busy, tx_done, rx_data, rx_error_status, rx_done_irq, rx_error_irq,
		input  base_tick, rx_line_high
	);
endinterface

//--- verilog/aseco_ctl.sv
// Controller end: APB registers, enable sequencing, interrupts
`timescale 1ns/1ns
module aseco_ctl (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	aseco_if.ctl             lnk,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);
	localparam logic [1:0] REEN = 2'(aseco_pkg::REENABLE_TICKS);
	localparam logic [1:0] TXW  = 2'(aseco_pkg::TXB_WAIT_TICKS);
	localparam int         DW   = aseco_pkg::DIV_W;
	localparam int         IW   = aseco_pkg::IRQ_W;

	logic [2:0]     want_q, want_d;
	logic [31:0]    mode_q, mode_d;
	logic [1:0]     apar_q, apar_d;
	logic           acl_q, acl_d, asl_q, asl_d, art_q, art_d;
	logic [DW-1:0]  adiv_q, adiv_d;
	logic           pwr_q, pwr_d, txe_q, txe_d, rxe_q, rxe_d;
	logic [1:0]     txg_q, txg_d, rxg_q, rxg_d, txw_q, txw_d;
	logic [7:0]     txh_q, txh_d, rxd_q, rxd_d;
	logic           txv_q, txv_d;
	logic [aseco_pkg::ERR_W-1:0] rxs_q, rxs_d;
	logic [IW-1:0]  ist_q, ist_d, imask_q, imask_d;
	logic [31:0]    prdata_q, prdata_d;
	logic           perr_q, perr_d;
	logic           setup, wr, go_tx, go_rx, pend_frame, pend_stop, pend_route, tx_wr;
	logic [1:0]     eff_par;
	logic [IW-1:0]  ev;

	always_comb begin
		setup = psel && !penable;
		wr = psel && penable && pwrite;
		want_d = want_q;
		mode_d = mode_q;
		imask_d = imask_q;
		txh_d = txh_q;
		txv_d = txv_q;
		eff_par = mode_q[aseco_pkg::MODE_LIN] ? aseco_pkg::PAR_NONE : mode_q[aseco_pkg::MODE_PAR +: 2];
		pend_frame = (apar_q != eff_par) || (acl_q != mode_q[aseco_pkg::MODE_CHAR])
			|| (adiv_q != mode_q[aseco_pkg::MODE_DIV +: DW]);
		pend_stop = asl_q != mode_q[aseco_pkg::MODE_STOP];
		pend_route = art_q != mode_q[aseco_pkg::MODE_ROUTE];
		go_tx = want_q[aseco_pkg::CTRL_POWER] && want_q[aseco_pkg::CTRL_TX];
		go_rx = want_q[aseco_pkg::CTRL_POWER] && want_q[aseco_pkg::CTRL_RX];
		// Power rises first and falls only after both enables
		pwr_d = want_q[aseco_pkg::CTRL_POWER] || txe_q || rxe_q;
		txe_d = txe_q ? go_tx : (go_tx && pwr_q && txg_q >= REEN && !pend_frame && !pend_stop);
		rxe_d = rxe_q ? go_rx : (go_rx && pwr_q && rxg_q >= REEN && !pend_frame && !pend_route
			&& lnk.rx_line_high);
		// Base-tick counts since an enable fell, and since transmit rose
		txg_d = txe_q ? 2'h0 : (!pwr_q ? REEN : ((lnk.base_tick && txg_q < REEN) ? txg_q + 2'h1 : txg_q));
		rxg_d = rxe_q ? 2'h0 : (!pwr_q ? REEN : ((lnk.base_tick && rxg_q < REEN) ? rxg_q + 2'h1 : rxg_q));
		txw_d = !txe_q ? 2'h0 : ((lnk.base_tick && txw_q < TXW) ? txw_q + 2'h1 : txw_q);
		tx_wr = txv_q && txe_q && (txw_q >= TXW) && !lnk.tx_busy;
		// Mode fields take effect only while the affected side is off
		apar_d = apar_q;
		acl_d = acl_q;
		adiv_d = adiv_q;
		asl_d = asl_q;
		art_d = art_q;
		if (!txe_q && !rxe_q) begin
			apar_d = eff_par;
			acl_d = mode_q[aseco_pkg::MODE_CHAR];
			adiv_d = mode_q[aseco_pkg::MODE_DIV +: DW];
		end
		if (!txe_q) begin
			asl_d = mode_q[aseco_pkg::MODE_STOP];
		end
		if (!rxe_q) begin
			art_d = mode_q[aseco_pkg::MODE_ROUTE];
		end
		if (tx_wr) begin
			txv_d = 1'b0;
		end
		ev = {lnk.tx_done, lnk.rx_error_irq, lnk.rx_done_irq};
		ist_d = ist_q;
		if (wr) begin
			unique case (paddr)
				aseco_pkg::OFF_CTRL: want_d = pwdata[2:0];
				aseco_pkg::OFF_MODE: mode_d = pwdata & 32'h0000_0F3F;
				aseco_pkg::OFF_TXDATA: if (!txv_q) begin
					txh_d = pwdata[7:0];
					txv_d = 1'b1;
				end
				aseco_pkg::OFF_IRQ_STAT: ist_d = ist_q & ~pwdata[IW-1:0];
				aseco_pkg::OFF_IRQ_MASK: imask_d = pwdata[IW-1:0];
				default: ;
			endcase
		end
		ist_d = ist_d | ev;
		rxd_d = rxd_q;
		rxs_d = rxs_q;
		if (lnk.rx_done_irq || lnk.rx_error_irq) begin
			rxd_d = lnk.rx_data;
			rxs_d = lnk.rx_error_status;
		end
		prdata_d = prdata_q;
		perr_d = perr_q;
		if (setup) begin
			perr_d = 1'b0;
			prdata_d = 32'h0000_0000;
			unique case (paddr)
				aseco_pkg::OFF_CTRL: prdata_d[2:0] = want_q;
				aseco_pkg::OFF_MODE: prdata_d = mode_q;
				aseco_pkg::OFF_TXDATA: prdata_d[7:0] = txh_q;
				aseco_pkg::OFF_RXDATA: begin
					prdata_d[7:0] = rxd_q;
					prdata_d[aseco_pkg::RXD_ERR +: aseco_pkg::ERR_W] = rxs_q;
				end
				aseco_pkg::OFF_STATUS: begin
					prdata_d[aseco_pkg::ST_POWER] = pwr_q;
					prdata_d[aseco_pkg::ST_TX] = txe_q;
					prdata_d[aseco_pkg::ST_RX] = rxe_q;
					prdata_d[aseco_pkg::ST_TXV] = txv_q;
					prdata_d[aseco_pkg::ST_BUSY] = lnk.tx_busy;
					prdata_d[aseco_pkg::ST_PEND] = pend_frame || pend_stop || pend_route;
					prdata_d[aseco_pkg::ST_LINE] = lnk.rx_line_high;
				end
				aseco_pkg::OFF_IRQ_STAT: prdata_d[IW-1:0] = ist_q;
				aseco_pkg::OFF_IRQ_MASK: prdata_d[IW-1:0] = imask_q;
				default: perr_d = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			want_q <= '0;
			mode_q <= aseco_pkg::MODE_RST;
			apar_q <= aseco_pkg::PAR_NONE;
			acl_q <= 1'b0;
			asl_q <= 1'b0;
			art_q <= 1'b0;
			adiv_q <= '0;
			pwr_q <= 1'b0;
			txe_q <= 1'b0;
			rxe_q <= 1'b0;
			txg_q <= REEN;
			rxg_q <= REEN;
			txw_q <= 2'h0;
			txh_q <= '0;
			txv_q <= 1'b0;
			rxd_q <= '0;
			rxs_q <= '0;
			ist_q <= '0;
			imask_q <= '0;
			prdata_q <= '0;
			perr_q <= 1'b0;
		end else begin
			want_q <= want_d;
			mode_q <= mode_d;
			apar_q <= apar_d;
			acl_q <= acl_d;
			asl_q <= asl_d;
			art_q <= art_d;
			adiv_q <= adiv_d;
			pwr_q <= pwr_d;
			txe_q <= txe_d;
			rxe_q <= rxe_d;
			txg_q <= txg_d;
			rxg_q <= rxg_d;
			txw_q <= txw_d;
			txh_q <= txh_d;
			txv_q <= txv_d;
			rxd_q <= rxd_d;
			rxs_q <= rxs_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			prdata_q <= prdata_d;
			perr_q <= perr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && perr_q;
	assign irq = |(ist_q & imask_q);
	assign lnk.power_en = pwr_q;
	assign lnk.tx_enable = txe_q;
	assign lnk.rx_enable = rxe_q;
	assign lnk.parity_sel = apar_q;
	assign lnk.char_len_sel = acl_q;
	assign lnk.stop_len_sel = asl_q;
	assign lnk.error_irq_route_sel = art_q;
	assign lnk.clk_div = adiv_q;
	assign lnk.tx_data = txh_q;
	assign lnk.tx_write = tx_wr;
endmodule

//--- bench/aseco_properties.sv
// Assertions on the link between the serial device and controller ends
`timescale 1ns/1ns
module aseco_properties (
	input wire logic                        core_clk,
	input wire logic                        resetn,
	input wire logic                        power_en,
	input wire logic                        tx_enable,
	input wire logic                        rx_enable,
	input wire logic [1:0]                  parity_sel,
	input wire logic                        char_len_sel,
	input wire logic                        stop_len_sel,
	input wire logic                        error_irq_route_sel,
	input wire logic                        tx_write,
	input wire logic                        tx_busy,
	input wire logic [aseco_pkg::ERR_W-1:0] rx_error_status,
	input wire logic                        rx_done_irq,
	input wire logic                        rx_error_irq,
	input wire logic                        base_tick,
	input wire logic                        rx_line_high
);
	logic [1:0] gap_q;
	logic [1:0] gap_d;
	logic       tick_q;
	logic       tick_d;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Base ticks since tx enable dropped, and tick seen since it rose
	always_comb begin
		gap_d = gap_q;
		tick_d = tx_enable & (tick_q | base_tick);
		if (tx_enable) begin
			gap_d = 2'h0;
		end else if (base_tick && gap_q != 2'h3) begin
			gap_d = gap_q + 2'h1;
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			gap_q <= 2'h3;
			tick_q <= 1'b0;
		end else begin
			gap_q <= gap_d;
			tick_q <= tick_d;
		end
	end
	sequence s_frame_end;
		rx_done_irq || rx_error_irq;
	endsequence
	sequence s_enables_off;
		!$past(tx_enable) && !$past(rx_enable);
	endsequence
	chk_route_err_only:
		assert property (rx_error_irq |-> !error_irq_route_sel && !rx_done_irq) else $error("bad error routing");
	chk_zero_par_quiet:
		assert property (s_frame_end ##0 parity_sel == aseco_pkg::PAR_ZERO |=> !rx_error_status[aseco_pkg::ERR_PARITY])
		else $error("parity flagged in zero parity");
	chk_tx_after_power:
		assert property ($rose(tx_enable) |-> $past(power_en)) else $error("tx enabled without power");
	chk_rx_line_high:
		assert property ($rose(rx_enable) |-> $past(power_en) && $past(rx_line_high)) else $error("rx enable bad");
	chk_power_last:
		assert property ($fell(power_en) |-> s_enables_off) else $error("power dropped before enables");
	chk_reenable_gap:
		assert property ($rose(tx_enable) |-> gap_q >= 2'h2) else $error("tx re-enabled too soon");
	chk_txb_after_tick:
		assert property (tx_write |-> tx_enable && tick_q && !tx_busy) else $error("early transmit write");
	chk_mode_frozen:
		assert property ($changed(parity_sel) || $changed(char_len_sel) |-> s_enables_off)
		else $error("format changed while enabled");
	chk_stop_frozen:
		assert property ($changed(stop_len_sel) |-> !$past(tx_enable)) else $error("stop count changed in tx");
	chk_route_frozen:
		assert property ($changed(error_irq_route_sel) |-> !$past(rx_enable)) else $error("route changed in rx");
	chk_tx_busy_hold:
		assert property (tx_write |=> tx_busy [*4]) else $error("busy not held after write");
endmodule

//--- bench/async_serial_enable_control_tb.sv
// Self-checking bench for the serial device and controller pair
`timescale 1ns/1ns
module async_serial_enable_control_tb;
	localparam int BT = 4;
	logic        core_clk;
	logic        resetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        rx_pin;
	logic        tx_pin;
	logic [31:0] rd;
	logic        slv;
	int          errors;
	int          n_tests;
	aseco_if lnk ();
	aseco_dev #(.BIT_TICKS(BT)) aseco_dev_i (
		.core_clk(core_clk), .resetn(resetn), .lnk(lnk), .serial_rx_pin(rx_pin), .serial_tx_pin(tx_pin)
	);
	aseco_ctl aseco_ctl_i (
		.core_clk(core_clk), .resetn(resetn), .lnk(lnk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
	);
	aseco_properties aseco_properties_i (
		.core_clk(core_clk), .resetn(resetn), .power_en(lnk.power_en), .tx_enable(lnk.tx_enable),
		.rx_enable(lnk.rx_enable), .parity_sel(lnk.parity_sel), .char_len_sel(lnk.char_len_sel),
		.stop_len_sel(lnk.stop_len_sel), .error_irq_route_sel(lnk.error_irq_route_sel),
		.tx_write(lnk.tx_write), .tx_busy(lnk.tx_busy), .rx_error_status(lnk.rx_error_status),
		.rx_done_irq(lnk.rx_done_irq), .rx_error_irq(lnk.rx_error_irq), .base_tick(lnk.base_tick),
		.rx_line_high(lnk.rx_line_high)
	);
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic close_out();
		$display("comparisons=%0d mismatches=%0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge core_clk);
		end
		if (n >= 50) begin
			errors++;
		end
		// Answer taken at the edge where pready is sampled high
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	function automatic int flen(input logic cl, input logic [1:0] ps, input logic s);
		return 9 + int'(cl) + int'(ps != aseco_pkg::PAR_NONE) + int'(s);
	endfunction
	// Line bits LSB first: start, data, parity, then idle-high stops
	function automatic logic [12:0] fbits(input logic [7:0] d, input logic cl, input logic [1:0] ps);
		logic [12:0] f;
		logic [7:0]  m;
		m = cl ? d : {1'b0, d[6:0]};
		f = 13'h1FFF;
		f[0] = 1'b0;
		f[7:1] = d[6:0];
		if (cl) begin
			f[8] = d[7];
		end
		if (ps != aseco_pkg::PAR_NONE) begin
			f[8 + int'(cl)] = (ps == aseco_pkg::PAR_ODD) ? ~^m : (ps == aseco_pkg::PAR_EVEN) ? ^m : 1'b0;
		end
		return f;
	endfunction
	task automatic tx_check(input logic [7:0] d, input logic cl, input logic [1:0] ps, input logic s);
		logic [12:0] f;
		int          n;
		f = fbits(d, cl, ps);
		n = 0;
		while (tx_pin !== 1'b0 && n < 500) begin
			n++;
			@(negedge core_clk);
		end
		if (n >= 500) begin
			errors++;
		end
		repeat (BT / 2) @(negedge core_clk);
		for (int k = 0; k < flen(cl, ps, s); k++) begin
			check({30'h0, tx_pin, lnk.tx_busy}, {30'h0, f[k], 1'b1});
			repeat (BT) @(negedge core_clk);
		end
		check({31'h0, lnk.tx_busy}, 32'h0);
		@(posedge core_clk);
	endtask
	task automatic rx_case(input logic [7:0] d, input logic cl, input logic [1:0] ps, input logic route,
		input logic bad, input logic ien);
		logic [12:0] f;
		logic [1:0]  e;
		int          n;
		f = fbits(d, cl, ps);
		n = flen(cl, ps, 1'b0);
		e = 2'h0;
		// Corrupt the parity bit; zero parity must ignore it
		if (bad && ps != aseco_pkg::PAR_NONE) begin
			f[n - 2] = ~f[n - 2];
			e = (ps == aseco_pkg::PAR_ZERO) ? 2'h0 : 2'h1;
		end
		for (int k = 0; k < n; k++) begin
			rx_pin <= f[k];
			repeat (BT) @(posedge core_clk);
		end
		rx_pin <= 1'b1;
		repeat (BT) @(posedge core_clk);
		apb(1'b0, aseco_pkg::OFF_IRQ_STAT, 32'h0);
		check(rd, (e == 2'h0 || route) ? 32'h1 : 32'h2);
		check({31'h0, irq}, {31'h0, ien});
		apb(1'b0, aseco_pkg::OFF_RXDATA, 32'h0);
		check(rd, {22'h0, e, cl ? d : {1'b0, d[6:0]}});
		apb(1'b1, aseco_pkg::OFF_IRQ_STAT, 32'h7);
		check({31'h0, irq}, 32'h0);
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		close_out();
	end
	initial begin
		logic [7:0] d;
		logic       lin;
		logic       route;
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rx_pin = 1'b1;
		errors = 0;
		n_tests = 0;
		void'($urandom(62));
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		apb(1'b0, aseco_pkg::OFF_MODE, 32'h0);
		check(rd, aseco_pkg::MODE_RST);
		apb(1'b0, aseco_pkg::OFF_STATUS, 32'h0);
		check(rd, 32'h40);
		apb(1'b0, 8'h1C, 32'h0);
		check({rd[30:0], slv}, 32'h1);
		// Receive must stay off while the line is held low
		rx_pin <= 1'b0;
		apb(1'b1, aseco_pkg::OFF_CTRL, 32'h7);
		repeat (20) @(posedge core_clk);
		apb(1'b0, aseco_pkg::OFF_STATUS, 32'h0);
		check({29'h0, rd[2:0]}, 32'h3);
		rx_pin <= 1'b1;
		apb(1'b1, aseco_pkg::OFF_IRQ_MASK, 32'h3);
		for (int i = 0; i < 16; i++) begin
			lin = (i == 7);
			route = 1'($urandom);
			d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			if (i == 15) begin
				apb(1'b1, aseco_pkg::OFF_IRQ_MASK, 32'h0);
			end
			apb(1'b1, aseco_pkg::OFF_MODE, {26'h0, lin, route, i[3:0]});
			apb(1'b0, aseco_pkg::OFF_STATUS, 32'h0);
			if (i != 0) begin
				check({31'h0, rd[aseco_pkg::ST_PEND]}, 32'h1);
			end
			apb(1'b1, aseco_pkg::OFF_CTRL, 32'h1);
			apb(1'b1, aseco_pkg::OFF_CTRL, 32'h7);
			rd = 32'h0;
			for (int n = 0; n < 40 && rd[2:0] !== 3'h7; n++) begin
				apb(1'b0, aseco_pkg::OFF_STATUS, 32'h0);
			end
			check({26'h0, rd[5:0]}, 32'h7);
			apb(1'b1, aseco_pkg::OFF_TXDATA, {24'h0, d});
			tx_check(d, i[2], lin ? 2'h0 : i[1:0], i[3]);
			apb(1'b1, aseco_pkg::OFF_IRQ_STAT, 32'h7);
			rx_case(d ^ 8'h5A, i[2], lin ? 2'h0 : i[1:0], route, i[0] ^ i[3], i != 15);
		end
		apb(1'b1, aseco_pkg::OFF_CTRL, 32'h1);
		apb(1'b1, aseco_pkg::OFF_CTRL, 32'h0);
		repeat (8) @(posedge core_clk);
		apb(1'b0, aseco_pkg::OFF_STATUS, 32'h0);
		check(rd, 32'h40);
		close_out();
	end
endmodule
